// File: hw/stdtm_core.sv
// 10-bit standard timer module core with register port and output pin
// Contract
// (R1) Five modes: compare output, timer, capture, single pulse, PWM; one input, one output.
// (R2) Ten-bit up-counter advancing on the software-chosen internal or external clock.
// (R3) Period compare uses counter bits 9..7; duty compare uses all ten bits.
// (R4) Software cannot load the counter; only on/off rising edge zeroes it.
// (R5) Counter clears on overflow or selected match, raising an interrupt event; overflow flags only at period code 0 (compare/timer: clear-select low).
// (R6) Count readable as read-only low/high pair; duty value read/write low/high pair.
// (R7) Pause bit holds the count; clearing it resumes from the held value.
// (R8) Clock-select codes pick sys/4, sys, high/16, high/64, time base, none, pin edges.
// (R9) On/off high runs; low stops and keeps count; rising edge zeroes count.
// (R10) Compare output mode: on/off rising edge restores pin initial level.
// (R11) Period code 000 means 1024 clocks; others 128 times code.
// (R12) Clear-select low makes a period match reset the counter.
// (R13) Period code zero lets the counter run to its maximum and overflow.
// (R14) Control 0: pause 7, clock select 6..4, on 3, period 2..0, reset zero.
// (R15) Mode field: 00 compare, 01 capture, 10 PWM or single pulse, 11 timer.
// (R16) Compare output mode: output-control bit gives pin level before any match.
// (R17) Overflow wraps 0x3FF to zero and counting continues.
`timescale 1ns/10ps
module stdtm_core
	import stdtm_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [DATA_W-1:0] o_rdata,
	input wire logic i_time_base_clock,
	input wire logic i_external_count_input,
	input wire logic i_capture_input,
	output logic o_timer_output_pin,
	output logic o_timer_output_en,
	output logic o_irq
);
	typedef struct packed {
		logic [DATA_W-1:0] ctrl0;
		logic [DATA_W-1:0] ctrl1;
		logic [CNT_W-1:0] duty_compare_value;
		logic [CNT_W-1:0] cnt;
		logic on_prev;
		logic out_lvl;
		logic sp_done;
		logic cap_prev;
		logic pin;
		logic pin_en;
		logic [DATA_W-1:0] rdata;
	} stdtm_core_s;

	stdtm_core_s r;
	stdtm_core_s n;

	logic tick;
	logic [EV_W-1:0] ev;
	logic [EV_W-1:0] irq_status;
	logic [EV_W-1:0] irq_mask;
	logic stat_wr;
	logic mask_wr;

	// Period match point as an 11-bit count; code zero stands for 1024
	function automatic logic [CNT_W:0] period_point(input logic [PER_W-1:0] code);
		period_point = {(code == 3'h0), code, 7'h00};
	endfunction

	// Register write strobe for one offset
	function automatic logic wr_hit(input logic wr, input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] ofs);
		wr_hit = wr && (a == ofs);
	endfunction

	logic pause_bit;
	logic on_off_bit;
	logic [2:0] clock_select_field;
	logic [PER_W-1:0] period_field;
	stdtm_mode_e mode;
	logic [1:0] io_sel;
	logic output_control_bit;
	logic pol;
	logic dpx;
	logic counter_clear_select;

	always_comb
	begin
		pause_bit = r.ctrl0[C0_PAUSE]; // (R14)
		clock_select_field = r.ctrl0[C0_CKSEL_LSB +: 3];
		on_off_bit = r.ctrl0[C0_ON];
		period_field = r.ctrl0[C0_PER_LSB +: PER_W];
		mode = stdtm_mode_e'(r.ctrl1[C1_MODE_LSB +: 2]); // (R15)
		io_sel = r.ctrl1[C1_IO_LSB +: 2];
		output_control_bit = r.ctrl1[C1_OC];
		pol = r.ctrl1[C1_POL];
		dpx = r.ctrl1[C1_DPX];
		counter_clear_select = r.ctrl1[C1_CCLR];
	end

	stdtm_clk_sel u_clk_sel
	(
		.i_sys_clk(i_sys_clk),
		.i_reset_n(i_reset_n),
		.i_clock_select_field(clock_select_field),
		.i_time_base_clock(i_time_base_clock),
		.i_external_count_input(i_external_count_input),
		.o_tick(tick)
	); // (R2) (R8)

	logic [CNT_W:0] cnt_plus;
	logic [CNT_W:0] per_pt;
	logic a_hit;
	logic p_hit;
	logic run;
	logic clr;
	logic on_rise;
	logic cap_edge;
	logic duty_act;
	logic pwm_act;

	always_comb
	begin
		n = r;
		ev = '0;
		clr = 1'b0;
		cnt_plus = {1'b0, r.cnt} + 11'h001;
		per_pt = period_point(period_field); // (R11)
		// Matches are taken on the count about to be reached
		a_hit = (cnt_plus == {1'b0, r.duty_compare_value}); // (R3)
		p_hit = (cnt_plus == per_pt); // (R3) (R13)
		on_rise = on_off_bit & ~r.on_prev;
		run = on_off_bit & ~pause_bit & tick; // (R7) (R9)
		n.on_prev = on_off_bit;
		n.cap_prev = i_capture_input;
		case (io_sel)
			2'b00: cap_edge = i_capture_input & ~r.cap_prev;
			2'b01: cap_edge = ~i_capture_input & r.cap_prev;
			2'b10: cap_edge = i_capture_input ^ r.cap_prev;
			default: cap_edge = 1'b0;
		endcase

		if (on_rise)
		begin
			n.cnt = '0; // (R4) (R9)
			n.sp_done = 1'b0;
			if (mode == MODE_COMPARE)
				n.out_lvl = output_control_bit; // (R10) (R16)
		end
		else if (run)
		begin
			case (mode)
				MODE_COMPARE, MODE_TIMER:
				begin
					clr = counter_clear_select ? a_hit : p_hit; // (R12)
					ev[EV_DUTY] = a_hit;
					ev[EV_PERIOD] = p_hit & ~counter_clear_select;
					if (mode == MODE_COMPARE && a_hit)
					begin
						case (io_sel)
							2'b01: n.out_lvl = 1'b0;
							2'b10: n.out_lvl = 1'b1;
							2'b11: n.out_lvl = ~r.out_lvl;
							default: n.out_lvl = r.out_lvl;
						endcase
					end
				end
				MODE_PWM:
				begin
					clr = dpx ? a_hit : p_hit;
					ev[EV_DUTY] = a_hit;
					ev[EV_PERIOD] = p_hit;
					if (clr)
						n.sp_done = 1'b1;
				end
				MODE_CAPTURE:
				begin
					clr = p_hit;
					ev[EV_PERIOD] = p_hit;
				end
				default: clr = 1'b0;
			endcase
			// Overflow needs no match: the low ten bits of 0x400 are zero
			n.cnt = clr ? '0 : cnt_plus[CNT_W-1:0]; // (R5) (R17)
		end

		if (wr_hit(i_wr, i_addr, OFS_CTRL0))
			n.ctrl0 = i_wdata;
		if (wr_hit(i_wr, i_addr, OFS_CTRL1))
			n.ctrl1 = i_wdata;
		if (wr_hit(i_wr, i_addr, OFS_DUTY_LO))
			n.duty_compare_value[7:0] = i_wdata; // (R6)
		if (wr_hit(i_wr, i_addr, OFS_DUTY_HI))
			n.duty_compare_value[9:8] = i_wdata[1:0]; // (R6)
		// A capture outranks a software write in the same cycle
		if (mode == MODE_CAPTURE && on_off_bit && cap_edge)
		begin
			n.duty_compare_value = r.cnt;
			ev[EV_DUTY] = 1'b1;
		end

		if (dpx)
			duty_act = ({1'b0, r.cnt} < per_pt);
		else
			duty_act = (r.cnt < r.duty_compare_value);
		case (io_sel)
			2'b00: pwm_act = 1'b0;
			2'b01: pwm_act = 1'b1;
			2'b10: pwm_act = on_off_bit & duty_act;
			default: pwm_act = on_off_bit & duty_act & ~r.sp_done;
		endcase
		case (mode) // (R1)
			MODE_COMPARE:
			begin
				n.pin = r.out_lvl ^ pol;
				n.pin_en = 1'b1;
			end
			MODE_PWM:
			begin
				n.pin = (pwm_act ? output_control_bit : ~output_control_bit) ^ pol;
				n.pin_en = 1'b1;
			end
			default:
			begin
				n.pin = 1'b0;
				n.pin_en = 1'b0;
			end
		endcase

		n.rdata = '0;
		if (i_rd)
		begin
			case (i_addr)
				OFS_CTRL0: n.rdata = r.ctrl0;
				OFS_CTRL1: n.rdata = r.ctrl1;
				OFS_CNT_LO: n.rdata = r.cnt[7:0]; // (R6)
				OFS_CNT_HI: n.rdata = {6'h00, r.cnt[9:8]};
				OFS_DUTY_LO: n.rdata = r.duty_compare_value[7:0];
				OFS_DUTY_HI: n.rdata = {6'h00, r.duty_compare_value[9:8]};
				OFS_IRQ_STAT: n.rdata = {6'h00, irq_status};
				OFS_IRQ_MASK: n.rdata = {6'h00, irq_mask};
				default: n.rdata = '0;
			endcase
		end
	end

	assign stat_wr = wr_hit(i_wr, i_addr, OFS_IRQ_STAT);
	assign mask_wr = wr_hit(i_wr, i_addr, OFS_IRQ_MASK);

	stdtm_irq u_irq
	(
		.i_sys_clk(i_sys_clk),
		.i_reset_n(i_reset_n),
		.i_event(ev),
		.i_stat_wr(stat_wr),
		.i_mask_wr(mask_wr),
		.i_wdata(i_wdata[EV_W-1:0]),
		.o_status(irq_status),
		.o_mask(irq_mask),
		.o_irq(o_irq)
	); // (R5)

	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			r <= '0;
			r.ctrl0 <= CTRL0_RST; // (R14)
			r.ctrl1 <= CTRL1_RST;
			r.duty_compare_value <= DUTY_RST;
		end
		else
			r <= n;
	end

	assign o_rdata = r.rdata;
	assign o_timer_output_pin = r.pin;
	assign o_timer_output_en = r.pin_en;
endmodule

// File: hw/stdtm_pkg.sv
// Shared constants and types of the standard timer module core
package stdtm_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int CNT_W = 10;
	localparam int PER_W = 3;
	localparam int EV_W = 2;

	localparam logic [ADDR_W-1:0] OFS_CTRL0 = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_CTRL1 = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_CNT_LO = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_CNT_HI = 4'h3;
	localparam logic [ADDR_W-1:0] OFS_DUTY_LO = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_DUTY_HI = 4'h5;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h6;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h7;

	localparam int C0_PAUSE = 7;
	localparam int C0_CKSEL_LSB = 4;
	localparam int C0_ON = 3;
	localparam int C0_PER_LSB = 0;
	localparam int C1_MODE_LSB = 6;
	localparam int C1_IO_LSB = 4;
	localparam int C1_OC = 3;
	localparam int C1_POL = 2;
	localparam int C1_DPX = 1;
	localparam int C1_CCLR = 0;
	localparam int EV_DUTY = 0;
	localparam int EV_PERIOD = 1;

	localparam logic [DATA_W-1:0] CTRL0_RST = 8'h00;
	localparam logic [DATA_W-1:0] CTRL1_RST = 8'h00;
	localparam logic [CNT_W-1:0] DUTY_RST = 10'h000;
	localparam logic [EV_W-1:0] IRQ_RST = 2'h0;

	// Divider terminal counts; the high clock is taken as the system clock
	localparam int DIV_W = 6;
	localparam logic [DIV_W-1:0] DIV_SYS4_TC = 6'h03;
	localparam logic [DIV_W-1:0] DIV_H16_TC = 6'h0F;
	localparam logic [DIV_W-1:0] DIV_H64_TC = 6'h3F;
	localparam int PER_SHIFT = 7;

	typedef enum logic [2:0] {
		CK_SYS_DIV4 = 3'b000,
		CK_SYS = 3'b001,
		CK_H_DIV16 = 3'b010,
		CK_H_DIV64 = 3'b011,
		CK_TIME_BASE = 3'b100,
		CK_RESERVED = 3'b101,
		CK_EXT_RISE = 3'b110,
		CK_EXT_FALL = 3'b111
	} stdtm_cksel_e;

	typedef enum logic [1:0] {
		MODE_COMPARE = 2'b00,
		MODE_CAPTURE = 2'b01,
		MODE_PWM = 2'b10,
		MODE_TIMER = 2'b11
	} stdtm_mode_e;
endpackage

// File: hw/stdtm_clk_sel.sv
// Counter clock selection: dividers, time-base tick and external pin edges
`timescale 1ns/10ps
module stdtm_clk_sel
	import stdtm_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic [2:0] i_clock_select_field,
	input wire logic i_time_base_clock,
	input wire logic i_external_count_input,
	output logic o_tick
);
	typedef struct packed {
		logic [DIV_W-1:0] div;
		logic ext_prev;
	} stdtm_clk_s;

	stdtm_clk_s r;
	stdtm_clk_s n;

	always_comb
	begin
		n = r;
		n.div = r.div + 6'h01;
		n.ext_prev = i_external_count_input;
		case (stdtm_cksel_e'(i_clock_select_field)) // (R8)
			CK_SYS_DIV4: o_tick = (r.div[1:0] == DIV_SYS4_TC[1:0]);
			CK_SYS: o_tick = 1'b1;
			CK_H_DIV16: o_tick = (r.div[3:0] == DIV_H16_TC[3:0]);
			CK_H_DIV64: o_tick = (r.div == DIV_H64_TC);
			CK_TIME_BASE: o_tick = i_time_base_clock;
			CK_EXT_RISE: o_tick = i_external_count_input & ~r.ext_prev;
			CK_EXT_FALL: o_tick = ~i_external_count_input & r.ext_prev;
			default: o_tick = 1'b0;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			r <= '0;
		else
			r <= n;
	end
endmodule

// File: hw/stdtm_irq.sv
// Sticky event status, mask and the level interrupt output
`timescale 1ns/10ps
module stdtm_irq
	import stdtm_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic [EV_W-1:0] i_event,
	input wire logic i_stat_wr,
	input wire logic i_mask_wr,
	input wire logic [EV_W-1:0] i_wdata,
	output logic [EV_W-1:0] o_status,
	output logic [EV_W-1:0] o_mask,
	output logic o_irq
);
	typedef struct packed {
		logic [EV_W-1:0] status;
		logic [EV_W-1:0] mask;
		logic irq;
	} stdtm_irq_s;

	stdtm_irq_s r;
	stdtm_irq_s n;

	// A new event in the clearing cycle is kept
	always_comb
	begin
		n = r;
		if (i_mask_wr)
			n.mask = i_wdata;
		for (int k = 0; k < EV_W; k++)
		begin
			if (i_stat_wr && i_wdata[k])
				n.status[k] = 1'b0;
			if (i_event[k])
				n.status[k] = 1'b1;
		end
		n.irq = |(n.status & n.mask);
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			r <= '0;
		else
			r <= n;
	end

	assign o_status = r.status;
	assign o_mask = r.mask;
	assign o_irq = r.irq;
endmodule

// File: dv/stdtm_core_sva.sv
// Port-level assertions for the standard timer core
`timescale 1ns/10ps
module stdtm_core_sva
	import stdtm_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [DATA_W-1:0] o_rdata,
	input wire logic o_timer_output_en,
	input wire logic o_irq
);
	// Shadows of written setup; calm_q waits out the register and edge-detect latency
	logic [7:0] c0_q;
	logic [7:0] c1_q;
	logic [1:0] mask_q;
	logic [1:0] calm_q;
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			c0_q <= 8'h00;
			c1_q <= 8'h00;
			mask_q <= 2'h0;
			calm_q <= 2'h0;
		end
		else
		begin
			if (i_wr && i_addr == OFS_CTRL0)
				c0_q <= i_wdata;
			if (i_wr && i_addr == OFS_CTRL1)
				c1_q <= i_wdata;
			if (i_wr && i_addr == OFS_IRQ_MASK)
				mask_q <= i_wdata[1:0];
			if (i_wr)
				calm_q <= 2'h0;
			else if (calm_q != 2'h3)
				calm_q <= calm_q + 2'h1;
		end
	end
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_reset_n);
	sequence lo_pair;
		i_rd && i_addr == OFS_CNT_LO ##1 i_rd && i_addr == OFS_CNT_LO;
	endsequence
	rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data outside its slot");
	unmapped_read_a: assert property (i_rd && i_addr[3] |=> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	high_bytes_a: assert property (i_rd && (i_addr == OFS_CNT_HI || i_addr == OFS_DUTY_HI)
		|=> o_rdata[7:2] == 6'h00) else $error("high byte carries extra bits");
	ctrl_back_a: assert property (i_wr && i_addr <= OFS_CTRL1 ##1 i_rd &&
		i_addr == $past(i_addr) |=> o_rdata == $past(i_wdata, 2)) else $error("control readback");
	out_enable_a: assert property (calm_q == 2'h3 |->
		o_timer_output_en == !c1_q[C1_MODE_LSB]) else $error("pin enable vs mode");
	irq_masked_a: assert property (calm_q == 2'h3 && mask_q == 2'h0 |-> !o_irq)
		else $error("interrupt while fully masked");
	pause_hold_a: assert property ((c0_q[C0_PAUSE] && calm_q == 2'h3) ##0 lo_pair
		|=> o_rdata == $past(o_rdata)) else $error("count moved while paused");
	count_step_a: assert property ((c0_q == 8'h18 && c1_q[1:0] == 2'h0 && calm_q == 2'h3)
		##0 lo_pair |=> o_rdata == $past(o_rdata) + 8'h01) else $error("count step");
endmodule
bind stdtm_core stdtm_core_sva u_sva (
	.i_sys_clk(i_sys_clk),
	.i_reset_n(i_reset_n),
	.i_addr(i_addr),
	.i_wdata(i_wdata),
	.i_wr(i_wr),
	.i_rd(i_rd),
	.o_rdata(o_rdata),
	.o_timer_output_en(o_timer_output_en),
	.o_irq(o_irq)
);

// File: dv/stdtm_core_bench.sv
// Self-checking bench for the standard timer core
`timescale 1ns/10ps
module stdtm_core_bench
	import stdtm_pkg::*;
;
	logic i_sys_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic [3:0] i_addr = 4'h0;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic tog = 1'b0;
	logic cap = 1'b0;
	logic [7:0] o_rdata;
	logic o_timer_output_pin;
	logic o_timer_output_en;
	logic o_irq;
	logic [7:0] a, b, c, d;
	int bad_count = 0;
	int check_count = 0;
	always #25 i_sys_clk = ~i_sys_clk;
	// One toggle feeds both the time-base tick and the count pin: a tick every other cycle
	always @(posedge i_sys_clk)
		tog <= ~tog;
	stdtm_core DUT (
		.i_sys_clk(i_sys_clk),
		.i_reset_n(i_reset_n),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.i_wr(i_wr),
		.i_rd(i_rd),
		.o_rdata(o_rdata),
		.i_time_base_clock(tog),
		.i_external_count_input(tog),
		.i_capture_input(cap),
		.o_timer_output_pin(o_timer_output_pin),
		.o_timer_output_en(o_timer_output_en),
		.o_irq(o_irq)
	);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wr(input logic [3:0] ad, input logic [7:0] dt);
		@(posedge i_sys_clk);
		i_addr <= ad;
		i_wdata <= dt;
		i_wr <= 1'b1;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
	endtask
	// Two back-to-back reads of one address
	task automatic rd2(input logic [3:0] ad, output logic [7:0] v1, output logic [7:0] v2);
		@(posedge i_sys_clk);
		i_addr <= ad;
		i_rd <= 1'b1;
		@(posedge i_sys_clk);
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		v1 = o_rdata;
		@(posedge i_sys_clk);
		v2 = o_rdata;
	endtask
	task automatic wrd(input logic [3:0] ad, input logic [7:0] dt, input logic [7:0] ex);
		wr(ad, dt);
		i_rd <= 1'b1;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		@(posedge i_sys_clk);
		chk(o_rdata, ex);
	endtask
	task automatic rise(input int lim, output int n);
		n = 0;
		while (o_irq && n < lim)
		begin
			@(posedge i_sys_clk);
			n++;
		end
		while (!o_irq && n < lim)
		begin
			@(posedge i_sys_clk);
			n++;
		end
	endtask
	// Cycles between two interrupt rises; the first rise only marks a period boundary to count from
	task automatic per(input logic [7:0] c0, input logic [7:0] c1, input int ex);
		int n;
		int lim;
		lim = 3 * ex + 2000;
		wr(OFS_CTRL0, 8'h00);
		wr(OFS_CTRL1, c1);
		wr(OFS_IRQ_MASK, c1[0] ? 8'h01 : 8'h02);
		wr(OFS_CTRL0, c0);
		wr(OFS_IRQ_STAT, 8'h03);
		rise(lim, n);
		if (ex == 0)
			chk(o_irq, 1'b0);
		else
		begin
			chk(n < lim, 1'b1);
			wr(OFS_IRQ_STAT, 8'h03);
			rise(lim, n);
			chk(16'(n + 2), 16'(ex));
			if (n >= lim)
				close_out();
		end
	endtask
	task automatic regs_t();
		rd2(OFS_CTRL0, a, b);
		chk(a, 8'h00);
		rd2(4'h9, a, b);
		chk(a, 8'h00);
		wrd(OFS_CTRL1, 8'h5A, 8'h5A);
		wrd(OFS_CTRL0, 8'hA5, 8'hA5);
		wrd(OFS_DUTY_LO, 8'h3C, 8'h3C);
		wrd(OFS_DUTY_HI, 8'hFF, 8'h03);
		wr(OFS_CTRL1, 8'h00);
		$display("register test done");
	endtask
	task automatic pause_t();
		wr(OFS_CTRL0, 8'h00);
		wr(OFS_CTRL0, 8'h18);
		repeat (20) @(posedge i_sys_clk);
		rd2(OFS_CNT_LO, a, b);
		chk(b - a, 8'h01);
		wr(OFS_CTRL0, 8'h98);
		repeat (4) @(posedge i_sys_clk);
		rd2(OFS_CNT_LO, a, b);
		repeat (10) @(posedge i_sys_clk);
		rd2(OFS_CNT_LO, c, d);
		chk(c, a);
		wr(OFS_CTRL0, 8'h18);
		rd2(OFS_CNT_LO, c, d);
		chk(c - a < 8'h08 && c != a, 1'b1);
		wr(OFS_CTRL0, 8'h10);
		rd2(OFS_CNT_LO, a, b);
		wr(OFS_CNT_LO, 8'hAA);
		rd2(OFS_CNT_LO, c, d);
		chk(c, a);
		wr(OFS_CTRL0, 8'h18);
		rd2(OFS_CNT_LO, c, d);
		chk(c < 8'h08, 1'b1);
		$display("pause test done");
	endtask
	task automatic irq_t();
		wr(OFS_CTRL0, 8'h00);
		wr(OFS_DUTY_LO, 8'h10);
		wr(OFS_DUTY_HI, 8'h00);
		wr(OFS_IRQ_MASK, 8'h00);
		wr(OFS_CTRL0, 8'h19);
		repeat (200) @(posedge i_sys_clk);
		wr(OFS_CTRL0, 8'h11);
		chk(o_irq, 1'b0);
		rd2(OFS_IRQ_STAT, a, b);
		chk(a, 8'h03);
		wr(OFS_IRQ_MASK, 8'h01);
		repeat (2) @(posedge i_sys_clk);
		chk(o_irq, 1'b1);
		wr(OFS_IRQ_STAT, 8'h01);
		repeat (2) @(posedge i_sys_clk);
		chk(o_irq, 1'b0);
		rd2(OFS_IRQ_STAT, a, b);
		chk(a, 8'h02);
		$display("interrupt test done");
	endtask
	task automatic pin_t(input logic oc);
		wr(OFS_CTRL0, 8'h00);
		wr(OFS_DUTY_LO, 8'h20);
		wr(OFS_CTRL1, {4'h3, oc, 3'h0});
		wr(OFS_CTRL0, 8'h19);
		repeat (4) @(posedge i_sys_clk);
		chk(o_timer_output_pin, oc);
		chk(o_timer_output_en, 1'b1);
		repeat (40) @(posedge i_sys_clk);
		chk(o_timer_output_pin, !oc);
		$display("output pin test done");
	endtask
	task automatic periods_t();
		int ex[8] = '{512, 128, 2048, 8192, 256, 0, 256, 256};
		per(8'h18, 8'h00, 1024);
		per(8'h1F, 8'h00, 896);
		wr(OFS_DUTY_LO, 8'h00);
		wr(OFS_DUTY_HI, 8'h01);
		per(8'h19, 8'h01, 256);
		for (int k = 0; k < 8; k++)
			per({1'b0, 3'(k), 4'h9}, 8'hC0, ex[k]);
		$display("period and clock test done");
	endtask
	// Count held by pause, so the captured value is known exactly
	task automatic cap_t();
		wr(OFS_CTRL0, 8'h00);
		wr(OFS_CTRL1, 8'h40);
		wr(OFS_IRQ_MASK, 8'h01);
		wr(OFS_IRQ_STAT, 8'h03);
		wr(OFS_CTRL0, 8'h19);
		repeat (30) @(posedge i_sys_clk);
		wr(OFS_CTRL0, 8'h99);
		rd2(OFS_CNT_LO, a, b);
		chk(b, a);
		cap <= 1'b1;
		repeat (3) @(posedge i_sys_clk);
		rd2(OFS_DUTY_LO, c, d);
		chk(c, a);
		chk(o_irq, 1'b1);
		chk(o_timer_output_en, 1'b0);
		cap <= 1'b0;
		$display("capture test done");
	endtask
	task automatic pwm_t();
		int hi;
		hi = 0;
		wr(OFS_CTRL0, 8'h00);
		wr(OFS_DUTY_LO, 8'h40);
		wr(OFS_DUTY_HI, 8'h00);
		wr(OFS_CTRL1, 8'hA8);
		wr(OFS_CTRL0, 8'h19);
		repeat (4) @(posedge i_sys_clk);
		for (int k = 0; k < 128; k++)
		begin
			@(posedge i_sys_clk);
			hi += o_timer_output_pin;
		end
		chk(16'(hi), 16'h0040);
		chk(o_timer_output_en, 1'b1);
		wr(OFS_CTRL1, 8'h9C);
		repeat (3) @(posedge i_sys_clk);
		chk(o_timer_output_pin, 1'b0);
		$display("pwm test done");
	endtask
	initial
	begin
		repeat (16) @(posedge i_sys_clk);
		i_reset_n <= 1'b1;
		regs_t();
		pause_t();
		irq_t();
		pin_t(1'b1);
		pin_t(1'b0);
		periods_t();
		cap_t();
		pwm_t();
		close_out();
	end
endmodule
